//--- logic/hwd_pkg.sv
// Package for the host watchdog timer: port map, register fields, reset
// values and timing counts.
// Assumes a 50 MHz controller clock and host I/O cycles of one clock each.
package hwd_pkg;
   // ---------------------------------------------------------------------
   // Port map
   // ---------------------------------------------------------------------
   // Base I/O port of the watchdog block.
   localparam logic [15:0] HWD_BASE_PORT = 16'h0680;
   // Register shifts added to the base port.
   localparam logic [7:0] HWD_TIME_BASE_OFS = 8'h65;
   localparam logic [7:0] HWD_COUNT_OFS = 8'h66;
   localparam logic [7:0] HWD_CONFIG_OFS = 8'h67;
   localparam logic [7:0] HWD_CTRL_OFS = 8'h68;
   // Address width of the host I/O space.
   localparam int HWD_ADDR_W = 16;

   // ---------------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------------
   // Time base: bit 7 selects minutes.
   localparam int HWD_TB_MIN_BIT = 7;
   // Configuration: keyboard, mouse restart enables and interrupt select.
   localparam int HWD_CFG_KBD_BIT = 1;
   localparam int HWD_CFG_MOUSE_BIT = 2;
   localparam int HWD_CFG_IRQ_LSB = 4;
   // Control: expired state, forced timeout, external trigger enable.
   localparam int HWD_CTL_EXPIRED_BIT = 0;
   localparam int HWD_CTL_FORCE_BIT = 2;
   localparam int HWD_CTL_EXT_BIT = 3;
   localparam logic [7:0] HWD_COUNT_RST = 8'h00;
   localparam logic [7:0] HWD_CONFIG_RST = 8'h00;
   localparam logic HWD_MIN_RST = 1'b0;

   // ---------------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------------
   // Clock rate and the one-second tick derived from it.
   localparam int HWD_CLK_HZ = 50000000;
   localparam int HWD_SEC_NS = 1000000000;
   localparam int HWD_CLK_NS = HWD_SEC_NS / HWD_CLK_HZ;
   localparam int HWD_SEC_CYCLES = HWD_SEC_NS / HWD_CLK_NS;
   // Seconds that make one minute.
   localparam int HWD_SEC_PER_MIN = 60;

   // Host I/O request, carried as one bundle.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [HWD_ADDR_W-1:0] addr;
      logic [7:0] wdata;
   } hwd_io_req_type;
endpackage : hwd_pkg

//--- logic/hwd_watchdog.sv
// Host watchdog timer: register file in host I/O space, second/minute
// time base, 8-bit countdown, restart sources and timeout routing.
// Assumes I/O requests are synchronous to I_CLK; keyboard, mouse and the
// external trigger are asynchronous pins and are synchronised here.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Registers decoded at port 680h plus shift.
// - Time base bit 7 picks minutes.
// - Zero count stops the watchdog; reset zero.
// - Nonzero count sets timeout in units.
// - Expiry raises mapped interrupt or reset.
// - Count write restarts from written value.
// - Config bit 1 lets keyboard restart.
// - Config bit 2 lets mouse restart.
// - Config bits 7:4 pick interrupt line.
// - Control bit 0 reads timeout state.
// - Control bit 2 forces timeout, self-clears.
// - Control bit 3 enables external trigger.
module hwd_watchdog
   import hwd_pkg::*;
#(
   parameter int SEC_CYCLES = HWD_SEC_CYCLES
) (
   // Clock and reset.
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   // Host I/O port access.
   input wire hwd_io_req_type I_IO_REQ,
   output logic [7:0] O_IO_RDATA,
   output logic O_IO_HIT,
   // Restart sources and external trigger pins.
   input wire logic I_KBD_ACTIVITY,
   input wire logic I_MOUSE_ACTIVITY,
   input wire logic I_EXTERNAL_TIMEOUT_TRIGGER,
   // Timeout outputs.
   output logic [15:0] O_IRQ,
   output logic O_WDT_RESET,
   output logic O_TIMEOUT
);

   // ---------------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------------
   // Full port addresses of the four registers.
   localparam logic [15:0] A_TB = HWD_BASE_PORT + {8'h00, HWD_TIME_BASE_OFS};
   localparam logic [15:0] A_CNT = HWD_BASE_PORT + {8'h00, HWD_COUNT_OFS};
   localparam logic [15:0] A_CFG = HWD_BASE_PORT + {8'h00, HWD_CONFIG_OFS};
   localparam logic [15:0] A_CTL = HWD_BASE_PORT + {8'h00, HWD_CTRL_OFS};
   wire sel_tb = I_IO_REQ.addr == A_TB;
   wire sel_cnt = I_IO_REQ.addr == A_CNT;
   wire sel_cfg = I_IO_REQ.addr == A_CFG;
   wire sel_ctl = I_IO_REQ.addr == A_CTL;
   wire wr_tb = I_IO_REQ.wr && sel_tb;
   wire wr_cnt = I_IO_REQ.wr && sel_cnt;
   wire wr_cfg = I_IO_REQ.wr && sel_cfg;
   wire wr_ctl = I_IO_REQ.wr && sel_ctl;
   wire any_sel = sel_tb || sel_cnt || sel_cfg || sel_ctl;

   // ---------------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------------
   logic minutes_reg; // Time base unit select.
   logic [7:0] count_reg; // Value last written to the count register.
   logic [7:0] remain_reg; // Units left before expiry.
   logic [7:0] config_reg; // Restart enables and interrupt select.
   logic ext_en_reg; // External trigger enable.
   logic expired_reg; // Sticky timeout state.
   logic [31:0] sec_cnt_reg; // Cycles within the current second.
   logic [5:0] min_cnt_reg; // Seconds within the current minute.
   logic [2:0] kbd_sync_reg, mouse_sync_reg, ext_sync_reg; // Synchronisers.

   // Pin synchronisers: two stages, then an edge stage read by logic.
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         kbd_sync_reg <= 3'h0;
         mouse_sync_reg <= 3'h0;
         ext_sync_reg <= 3'h0;
      end else begin
         kbd_sync_reg <= {kbd_sync_reg[1:0], I_KBD_ACTIVITY};
         mouse_sync_reg <= {mouse_sync_reg[1:0], I_MOUSE_ACTIVITY};
         ext_sync_reg <= {ext_sync_reg[1:0], I_EXTERNAL_TIMEOUT_TRIGGER};
      end
   end

   // Rising edges of activity; the first stage is never looked at here.
   wire kbd_edge = kbd_sync_reg[1] && !kbd_sync_reg[2];
   wire mouse_edge = mouse_sync_reg[1] && !mouse_sync_reg[2];
   wire ext_level = ext_sync_reg[1];

   // ---------------------------------------------------------------------
   // Time base
   // ---------------------------------------------------------------------
   // second tick
   wire sec_tick = sec_cnt_reg == 32'(SEC_CYCLES - 1);
   wire min_tick = sec_tick && (min_cnt_reg == 6'(HWD_SEC_PER_MIN - 1));
   wire unit_tick = minutes_reg ? min_tick : sec_tick;
   wire running = remain_reg != 8'h00;

   // Restart sources: a reload, or enabled keyboard or mouse activity.
   // keyboard restart
   wire kbd_restart = config_reg[HWD_CFG_KBD_BIT] && kbd_edge;
   wire mouse_restart = config_reg[HWD_CFG_MOUSE_BIT] && mouse_edge;
   wire act_restart = (kbd_restart || mouse_restart) && running;

   // Timeout causes.
   wire count_expire = running && unit_tick && remain_reg == 8'h01;
   wire force_to = wr_ctl && I_IO_REQ.wdata[HWD_CTL_FORCE_BIT];
   wire ext_to = ext_en_reg && ext_level;
   // An activity restart in the expiry cycle reloads the count, so the
   // expiry that it overtakes must not be reported as well.
   wire timeout_event = (count_expire && !wr_cnt && !act_restart) ||
      force_to || ext_to;

   // Prescaler restarts with each reload so the first unit is full length.
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         sec_cnt_reg <= 32'h0;
         min_cnt_reg <= 6'h00;
      end else if (wr_cnt || act_restart || sec_tick) begin
         sec_cnt_reg <= 32'h0;
         if (wr_cnt || act_restart || min_tick) begin
            min_cnt_reg <= 6'h00;
         end else begin
            min_cnt_reg <= min_cnt_reg + 6'h01;
         end
      end else begin
         sec_cnt_reg <= sec_cnt_reg + 32'h1;
      end
   end

   // ---------------------------------------------------------------------
   // Host-written registers
   // ---------------------------------------------------------------------
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         minutes_reg <= HWD_MIN_RST;
         config_reg <= HWD_CONFIG_RST;
         ext_en_reg <= 1'b0;
      end else begin
         if (wr_tb) begin
            minutes_reg <= I_IO_REQ.wdata[HWD_TB_MIN_BIT];
         end
         if (wr_cfg) begin
            config_reg <= I_IO_REQ.wdata;
         end
         if (wr_ctl) begin
            ext_en_reg <= I_IO_REQ.wdata[HWD_CTL_EXT_BIT];
         end
      end
   end

   // Countdown: a write reloads, activity restarts, ticks decrement.
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         count_reg <= HWD_COUNT_RST;
         remain_reg <= HWD_COUNT_RST;
      end else if (wr_cnt) begin
         count_reg <= I_IO_REQ.wdata;
         remain_reg <= I_IO_REQ.wdata;
      end else if (act_restart) begin
         remain_reg <= count_reg;
      end else if (running && unit_tick) begin
         remain_reg <= remain_reg - 8'h01;
      end
   end

   // sticky expiry; a new timeout wins over a reload's clear.
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         expired_reg <= 1'b0;
      end else if (timeout_event) begin
         expired_reg <= 1'b1;
      end else if (wr_cnt) begin
         expired_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------------
   // interrupt select
   wire [3:0] irq_sel = config_reg[HWD_CFG_IRQ_LSB +: 4];
   wire [15:0] irq_next = (timeout_event || expired_reg) && irq_sel != 4'h0
      ? 16'h0001 << irq_sel : 16'h0000;
   // interrupt or reset; reset is used when no interrupt is mapped.
   wire rst_next = (timeout_event || expired_reg) && irq_sel == 4'h0;
   // status readback; write-only bits read as zero.
   wire [7:0] ctl_rd = {4'h0, ext_en_reg, 2'b00, expired_reg};
   wire [7:0] rd_next = sel_cfg ? config_reg : sel_ctl ? ctl_rd : 8'h00;

   // Output flops: all outputs come straight from here.
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_IO_RDATA <= 8'h00;
         O_IO_HIT <= 1'b0;
         O_IRQ <= 16'h0000;
         O_WDT_RESET <= 1'b0;
         O_TIMEOUT <= 1'b0;
      end else begin
         O_IO_RDATA <= I_IO_REQ.rd ? rd_next : 8'h00;
         O_IO_HIT <= I_IO_REQ.rd && any_sel;
         O_IRQ <= irq_next;
         O_WDT_RESET <= rst_next;
         O_TIMEOUT <= timeout_event;
      end
   end

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   property p_zero_stops;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      (wr_cnt && I_IO_REQ.wdata == 8'h00 && !force_to && !ext_to)
         ##1 (!I_IO_REQ.wr && !ext_to)[*2] |-> !expired_reg;
   endproperty
   a_zero_stops: assert property (p_zero_stops) else $error("zero count ran");
   property p_reload;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      wr_cnt |=> remain_reg == $past(I_IO_REQ.wdata);
   endproperty
   a_reload: assert property (p_reload) else $error("reload missed");
   property p_force;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      force_to |=> O_TIMEOUT && expired_reg;
   endproperty
   a_force: assert property (p_force) else $error("force lost");
   property p_expire;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      count_expire && !wr_cnt && !act_restart |=>
         expired_reg && remain_reg == 8'h00;
   endproperty
   a_expire: assert property (p_expire) else $error("expiry lost");
   property p_irq;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      expired_reg && irq_sel != 4'h0 |=> O_IRQ[$past(irq_sel)] && !O_WDT_RESET;
   endproperty
   a_irq: assert property (p_irq) else $error("irq route wrong");
   property p_sticky;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      expired_reg && !wr_cnt |=> expired_reg;
   endproperty
   a_sticky: assert property (p_sticky) else $error("expiry dropped");
   property p_status;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      I_IO_REQ.rd && sel_ctl |=> O_IO_RDATA[0] == $past(expired_reg);
   endproperty
   a_status: assert property (p_status) else $error("status wrong");
   property p_ext;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      ext_en_reg && ext_level |=> O_TIMEOUT;
   endproperty
   a_ext: assert property (p_ext) else $error("ext trigger lost");
   property p_kbd;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      kbd_restart && running && !wr_cnt |=> remain_reg == $past(count_reg);
   endproperty
   a_kbd: assert property (p_kbd) else $error("kbd restart lost");
   c_expire: cover property (@(posedge I_CLK) count_expire);
   c_force: cover property (@(posedge I_CLK) force_to);
   c_mouse: cover property (@(posedge I_CLK) mouse_restart && running);
   c_min: cover property (@(posedge I_CLK) minutes_reg && min_tick);
endmodule : hwd_watchdog

`default_nettype wire

//--- tb/hwd_host.sv
// Host model: issues one-clock I/O cycles to the watchdog ports.
// Assumes the bench clock; requests change on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module hwd_host
   import hwd_pkg::*;
(
   // Clock and read return.
   input wire logic clk,
   input wire logic [7:0] i_rdata,
   input wire logic i_hit,
   // Request bundle.
   output var hwd_io_req_type o_req
);
   // One access; r returns {hit, data} taken the cycle after the request.
   // Idle shows inverted address and data, so stale values never match.
   task automatic io(input logic w, input logic [15:0] a,
      input logic [7:0] d, output logic [8:0] r);
      @(negedge clk);
      o_req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clk);
      r = {i_hit, i_rdata};
      o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : io
   initial o_req = '0;
endmodule : hwd_host
`default_nettype wire

//--- tb/hwd_watchdog_tb.sv
// Self-checking bench for the host watchdog timer.
// Assumes a ten-cycle second so that minute runs stay short.
`timescale 1ns/1ns
`default_nettype none
module hwd_watchdog_tb
   import hwd_pkg::*;
;
   localparam int S = 10;
   logic clk, rst, kbd, mouse, ext, hit, wrst, tmo;
   logic [7:0] rdata;
   logic [15:0] irq;
   logic [8:0] r;
   hwd_io_req_type req;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;

   hwd_watchdog #(.SEC_CYCLES(S)) dut_u (.I_CLK(clk), .I_SYS_RST(rst),
      .I_IO_REQ(req), .O_IO_RDATA(rdata), .O_IO_HIT(hit),
      .I_KBD_ACTIVITY(kbd), .I_MOUSE_ACTIVITY(mouse),
      .I_EXTERNAL_TIMEOUT_TRIGGER(ext), .O_IRQ(irq),
      .O_WDT_RESET(wrst), .O_TIMEOUT(tmo));
   hwd_host host_u (.clk(clk), .i_rdata(rdata), .i_hit(hit), .o_req(req));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict

   // A hang is cut short well beyond the longest scenario.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic chk(input string n, input logic [15:0] e, g);
      num_checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         n_fail++;
      end
   endtask : chk

   function automatic logic [15:0] ad(input logic [7:0] o);
      return HWD_BASE_PORT + {8'h00, o};
   endfunction : ad

   task automatic wr(input logic [7:0] o, d);
      host_u.io(1'b1, ad(o), d, r);
   endtask : wr

   task automatic rd(input logic [7:0] o, input logic [8:0] e, string n);
      host_u.io(1'b0, ad(o), 8'h00, r);
      chk(n, 16'(e), 16'(r));
   endtask : rd

   // Counts cycles until a timeout pulse, at most lim.
   task automatic wait_tmo(input int lim, output int t);
      for (t = 0; t < lim && tmo !== 1'b1; t++) @(negedge clk);
   endtask : wait_tmo

   task automatic chk_tmo(input string n, input int lo, hi);
      int t;
      wait_tmo(hi + 1, t);
      num_checks++;
      if (t < lo || t > hi) begin
         $display("ERROR %s expected %0d..%0d seen %0d", n, lo, hi, t);
         n_fail++;
      end
   endtask : chk_tmo

   task automatic t_reset();
      chk("outputs", 16'h0000, irq | {wrst, tmo, hit});
      rd(HWD_CONFIG_OFS, 9'h100, "config");
      rd(HWD_CTRL_OFS, 9'h100, "control");
      rd(HWD_COUNT_OFS, 9'h100, "count");
      host_u.io(1'b0, ad(8'h69), 8'h00, r);
      chk("unmapped", 16'h0000, 16'(r));
      $display("t_reset done");
   endtask : t_reset

   task automatic t_sec();
      int t;
      host_u.io(1'b0, ad(HWD_CONFIG_OFS), 8'h00, r);
      wr(HWD_CONFIG_OFS, r[7:0] | 8'h50);
      wr(HWD_TIME_BASE_OFS, 8'h00);
      wr(HWD_COUNT_OFS, 8'h03);
      chk_tmo("sec", 3*S-2, 3*S+3);
      @(negedge clk);
      chk("irq5", 16'h0020, irq);
      chk("rst", 16'h0000, 16'(wrst));
      rd(HWD_CTRL_OFS, 9'h101, "expired");
      wr(HWD_COUNT_OFS, 8'h00);
      @(negedge clk);
      chk("cleared", 16'h0000, irq);
      wait_tmo(60, t);
      chk("stopped", 16'd60, 16'(t));
      $display("t_sec done");
   endtask : t_sec

   task automatic t_restart();
      wr(HWD_COUNT_OFS, 8'h04);
      repeat (25) @(negedge clk);
      wr(HWD_COUNT_OFS, 8'h04);
      chk_tmo("rewrite", 4*S-2, 4*S+3);
      wr(HWD_COUNT_OFS, 8'h00);
      $display("t_restart done");
   endtask : t_restart

   task automatic t_act();
      for (int s = 0; s < 2; s++) begin
         for (int en = 0; en < 2; en++) begin
            wr(HWD_CONFIG_OFS, 8'(en << (s + 1)));
            wr(HWD_COUNT_OFS, 8'h04);
            repeat (25) @(negedge clk);
            if (s == 0) kbd = 1'b1;
            else mouse = 1'b1;
            repeat (2) @(negedge clk);
            kbd = 1'b0;
            mouse = 1'b0;
            if (en == 1) chk_tmo("act on", 37, 46);
            else chk_tmo("act off", 10, 16);
            wr(HWD_COUNT_OFS, 8'h00);
         end
      end
      $display("t_act done");
   endtask : t_act

   task automatic t_min();
      wr(HWD_CONFIG_OFS, 8'h00);
      wr(HWD_TIME_BASE_OFS, 8'h80);
      wr(HWD_COUNT_OFS, 8'h01);
      chk_tmo("minute", 60*S-2, 60*S+3);
      @(negedge clk);
      chk("reset out", 16'h0001, {irq[14:0], wrst});
      wr(HWD_COUNT_OFS, 8'h00);
      wr(HWD_TIME_BASE_OFS, 8'h00);
      $display("t_min done");
   endtask : t_min

   task automatic t_force();
      for (int n = 1; n < 16; n++) begin
         wr(HWD_CONFIG_OFS, 8'(n << 4));
         wr(HWD_CTRL_OFS, 8'h04);
         chk_tmo("force", 0, 2);
         @(negedge clk);
         chk("irq map", 16'(1 << n), irq);
         rd(HWD_CTRL_OFS, 9'h101, "self clear");
         wr(HWD_COUNT_OFS, 8'h00);
      end
      $display("t_force done");
   endtask : t_force

   task automatic t_ext();
      int t;
      wr(HWD_CTRL_OFS, 8'h00);
      ext = 1'b1;
      wait_tmo(10, t);
      chk("ext off", 16'd10, 16'(t));
      ext = 1'b0;
      wr(HWD_CTRL_OFS, 8'h08);
      ext = 1'b1;
      chk_tmo("ext on", 0, 6);
      ext = 1'b0;
      wr(HWD_CTRL_OFS, 8'h00);
      wr(HWD_COUNT_OFS, 8'h00);
      $display("t_ext done");
   endtask : t_ext

   initial begin
      rst = 1'b1;
      kbd = 1'b0;
      mouse = 1'b0;
      ext = 1'b0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_sec();
      t_restart();
      t_act();
      t_min();
      t_force();
      t_ext();
      give_verdict();
   end
endmodule : hwd_watchdog_tb
`default_nettype wire
